// ===== hdl/calendar_counter_unit_map.svh
// Register offsets, field positions, reset values and timing counts of the real-time counter control block
`ifndef CALENDAR_COUNTER_UNIT_MAP_SVH
`define CALENDAR_COUNTER_UNIT_MAP_SVH

`define CALENDAR_COUNTER_UNIT_OFS_MAIN_CTRL  8'h00
`define CALENDAR_COUNTER_UNIT_OFS_EN_CLEAR   8'h08
`define CALENDAR_COUNTER_UNIT_OFS_EN_SET     8'h0A
`define CALENDAR_COUNTER_UNIT_OFS_FLAGS      8'h0C
`define CALENDAR_COUNTER_UNIT_OFS_DEBUG      8'h0E
`define CALENDAR_COUNTER_UNIT_OFS_BUSY       8'h10
`define CALENDAR_COUNTER_UNIT_OFS_TRIM       8'h14
`define CALENDAR_COUNTER_UNIT_OFS_COUNT      8'h18

`define CALENDAR_COUNTER_UNIT_BIT_WRAP       15
`define CALENDAR_COUNTER_UNIT_BIT_TAMPER     14
`define CALENDAR_COUNTER_UNIT_IRQ_MASK       16'hC0FF
`define CALENDAR_COUNTER_UNIT_PER_TAP        2

`define CALENDAR_COUNTER_UNIT_CTRL_SOFT_RST  0
`define CALENDAR_COUNTER_UNIT_CTRL_ENABLE    1
`define CALENDAR_COUNTER_UNIT_CTRL_RSYNC     15
`define CALENDAR_COUNTER_UNIT_DBG_RUN        0
`define CALENDAR_COUNTER_UNIT_TRIM_SIGN      7

`define CALENDAR_COUNTER_UNIT_BUSY_SOFT_RST  0
`define CALENDAR_COUNTER_UNIT_BUSY_ENABLE    1
`define CALENDAR_COUNTER_UNIT_BUSY_TRIM      2
`define CALENDAR_COUNTER_UNIT_BUSY_COUNT     3
`define CALENDAR_COUNTER_UNIT_BUSY_RSYNC     15

`define CALENDAR_COUNTER_UNIT_SYNC_NS        20
`define CALENDAR_COUNTER_UNIT_CLK_NS         5
`define CALENDAR_COUNTER_UNIT_SYNC_CYC       3'((`CALENDAR_COUNTER_UNIT_SYNC_NS + `CALENDAR_COUNTER_UNIT_CLK_NS - 1) / `CALENDAR_COUNTER_UNIT_CLK_NS)

`define CALENDAR_COUNTER_UNIT_RST_16         16'h0000
`define CALENDAR_COUNTER_UNIT_RST_8          8'h00
`define CALENDAR_COUNTER_UNIT_RST_32         32'h00000000

`endif

// ===== hdl/calendar_counter_unit_pkg.sv
// Types shared by the real-time counter control block
package calendar_counter_unit_pkg;

  // One software access on the register port
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } calendar_counter_unit_bus_t;

  // Indexes of the synchronisation trackers
  typedef enum logic [2:0] {
    CALENDAR_COUNTER_UNIT_SY_SOFT_RST = 3'h0,
    CALENDAR_COUNTER_UNIT_SY_ENABLE = 3'h1,
    CALENDAR_COUNTER_UNIT_SY_TRIM   = 3'h2,
    CALENDAR_COUNTER_UNIT_SY_COUNT  = 3'h3,
    CALENDAR_COUNTER_UNIT_SY_RSYNC  = 3'h4
  } calendar_counter_unit_sync_t;

endpackage : calendar_counter_unit_pkg

// ===== hdl/calendar_counter_unit_regs.sv
// Control, interrupt flag, debug, sync-busy and rate-trim logic of the 32-bit real-time counter
//
// Summary of operation
// RULE1: Writing one to enable-set bit 15 turns on the wrap interrupt enable.
// RULE2: Writing ones to enable-set bits 7..0 turn on matching periodic enables.
// RULE3: Enable-set and enable-clear addresses share one set of enable bits.
// RULE4: Wrap flag bit 15 sets on the counter cycle after the counter wraps.
// RULE5: Wrap flag with its enable raises the interrupt request.
// RULE6: Writing one to flag bit 15 clears it; zero does nothing.
// RULE7: A tamper event sets flag bit 14 and requests interrupt if enabled.
// RULE8: Writing one to flag bit 14 clears it; zero does nothing.
// RULE9: Periodic flag n sets on a rising prescaler bit n+2.
// RULE10: Periodic flag n with its enable raises the interrupt request.
// RULE11: Writing one to periodic flag n clears it; zero leaves it.
// RULE12: Run-while-halted zero stops counting during debug halt; one keeps counting.
// RULE13: Run-while-halted survives soft reset; only the system reset clears it.
// RULE14: Busy bit 15 shows read-sync-enable write still crossing.
// RULE15: Busy bit 3 shows counter value read or write sync in progress.
// RULE16: Busy bit 2 shows rate trim write being synchronised.
// RULE17: Busy bit 1 shows enable bit write being synchronised.
// RULE18: Busy bit 0 holds until soft reset completes; other accesses are barred.
// RULE19: Trim bit 7 picks sign: zero slows the counter, one speeds it.
// RULE20: Trim magnitude zero disables correction; 1..127 adjust rate proportionally.
// RULE21: The counter value register holds the full 32-bit count that wraps.
// RULE22: A flag event meeting a clearing write in one cycle leaves it set.
// RULE23: Interrupt request is the OR of each flag ANDed with its enable.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "calendar_counter_unit_map.svh"

module calendar_counter_unit_regs
  import calendar_counter_unit_pkg::*;
#(
  parameter int PRESC_W = 10
)(
  input  wire logic      core_clk,
  input  wire logic      rst,
  input  wire calendar_counter_unit_bus_t bus,
  input  wire logic      counter_clock,
  input  wire logic      tamper_in,
  input  wire logic      debug_halt,
  output logic [31:0]    rd_data,
  output logic           irq
);

  // The taps n+2 for n = 7 must exist in the prescaler
  if (PRESC_W < `CALENDAR_COUNTER_UNIT_PER_TAP + 8 || PRESC_W > 16)
  begin : g_bad_presc
    $error("PRESC_W must lie between 10 and 16");
  end

  // Bits that are written as ones on a given offset
  function automatic logic [15:0] wr_ones(input calendar_counter_unit_bus_t b, input logic [7:0] ofs);
    wr_ones = (b.wr && b.addr == ofs) ? (b.wdata[15:0] & `CALENDAR_COUNTER_UNIT_IRQ_MASK) : `CALENDAR_COUNTER_UNIT_RST_16;
  endfunction : wr_ones

  logic [2:0]          pin_s1_q;
  logic [2:0]          pin_s2_q;
  logic                cclk_prev_q;
  logic                tamper_prev_q;
  logic                tick;
  logic                tamper_ev;
  logic                halted;
  logic [15:0]         enable_q;
  logic [15:0]         flags_q;
  logic [15:0]         flags_d;
  logic [15:0]         flag_set;
  logic [7:0]          debug_q;
  logic [7:0]          trim_q;
  logic [7:0]          trim_eff_q;
  logic                ctrl_en_q;
  logic                ctrl_rsync_q;
  logic                en_eff_q;
  logic [31:0]         count_q;
  logic [31:0]         count_snap_q;
  logic [PRESC_W-1:0]  presc_q;
  logic [PRESC_W-1:0]  presc_d;
  logic [PRESC_W-1:0]  trim_cnt_q;
  logic [7:0]          per_edge;
  logic                wrap_q;
  logic                run;
  logic                presc_wrap;
  logic [2:0]          sync_cnt_q [5];
  logic [4:0]          busy;
  logic [4:0]          sync_start;
  logic [4:0]          sync_done;
  logic                soft_rst;
  logic                allow;
  logic                ctrl_wr;
  logic [31:0]         busy_word;

  // Pins from outside pass two flops before anything looks at them
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end
    else
    begin
      pin_s1_q <= {debug_halt, tamper_in, counter_clock};
      pin_s2_q <= pin_s1_q;
    end
  end

  // Edge history for the counter clock and tamper pin
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cclk_prev_q   <= 1'b0;
      tamper_prev_q <= 1'b0;
    end
    else
    begin
      cclk_prev_q   <= pin_s2_q[0];
      tamper_prev_q <= pin_s2_q[1];
    end
  end

  assign tick      = pin_s2_q[0] & ~cclk_prev_q;
  assign tamper_ev = pin_s2_q[1] & ~tamper_prev_q;
  assign halted    = pin_s2_q[2];

  // Soft reset holds the other registers, except debug control, at reset until its sync ends
  assign soft_rst = busy[CALENDAR_COUNTER_UNIT_SY_SOFT_RST];
  assign allow    = ~soft_rst; // RULE18
  assign ctrl_wr  = bus.wr && bus.addr == `CALENDAR_COUNTER_UNIT_OFS_MAIN_CTRL;

  // Sync trackers: each write to a synchronised field is busy a fixed time
  assign sync_start[CALENDAR_COUNTER_UNIT_SY_SOFT_RST] = ctrl_wr && bus.wdata[`CALENDAR_COUNTER_UNIT_CTRL_SOFT_RST] && !soft_rst;
  assign sync_start[CALENDAR_COUNTER_UNIT_SY_ENABLE] = ctrl_wr && allow; // RULE17
  assign sync_start[CALENDAR_COUNTER_UNIT_SY_RSYNC]  = ctrl_wr && allow; // RULE14
  assign sync_start[CALENDAR_COUNTER_UNIT_SY_TRIM]   = bus.wr && bus.addr == `CALENDAR_COUNTER_UNIT_OFS_TRIM && allow; // RULE16
  assign sync_start[CALENDAR_COUNTER_UNIT_SY_COUNT]  = (bus.wr || bus.rd) && bus.addr == `CALENDAR_COUNTER_UNIT_OFS_COUNT && allow; // RULE15

  always_ff @(posedge core_clk)
  begin
    for (int i = 0; i < 5; i++)
    begin
      if (rst)
        sync_cnt_q[i] <= 3'h0;
      else if (sync_start[i])
        sync_cnt_q[i] <= `CALENDAR_COUNTER_UNIT_SYNC_CYC;
      else if (sync_cnt_q[i] != 3'h0)
        sync_cnt_q[i] <= sync_cnt_q[i] - 3'h1;
    end
  end

  always_comb
  begin
    for (int i = 0; i < 5; i++)
    begin
      busy[i]      = sync_cnt_q[i] != 3'h0;
      sync_done[i] = sync_cnt_q[i] == 3'h1;
    end
  end

  // Main control fields; the soft reset bit itself is read back from the busy state
  always_ff @(posedge core_clk)
  begin
    if (rst || soft_rst)
    begin
      ctrl_en_q    <= 1'b0;
      ctrl_rsync_q <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      ctrl_en_q    <= bus.wdata[`CALENDAR_COUNTER_UNIT_CTRL_ENABLE];
      ctrl_rsync_q <= bus.wdata[`CALENDAR_COUNTER_UNIT_CTRL_RSYNC];
    end
  end

  // Written values only take hold in the counter once their sync ends
  always_ff @(posedge core_clk)
  begin
    if (rst || soft_rst)
    begin
      en_eff_q   <= 1'b0;
      trim_eff_q <= `CALENDAR_COUNTER_UNIT_RST_8;
    end
    else
    begin
      if (sync_done[CALENDAR_COUNTER_UNIT_SY_ENABLE])
        en_eff_q <= ctrl_en_q; // RULE17
      if (sync_done[CALENDAR_COUNTER_UNIT_SY_TRIM])
        trim_eff_q <= trim_q; // RULE16
    end
  end

  // Debug control keeps its value across soft reset
  always_ff @(posedge core_clk)
  begin
    if (rst)
      debug_q <= `CALENDAR_COUNTER_UNIT_RST_8; // RULE13
    else if (bus.wr && bus.addr == `CALENDAR_COUNTER_UNIT_OFS_DEBUG && allow)
      debug_q <= {7'h00, bus.wdata[`CALENDAR_COUNTER_UNIT_DBG_RUN]};
  end

  // Rate trim as written by software
  always_ff @(posedge core_clk)
  begin
    if (rst || soft_rst)
      trim_q <= `CALENDAR_COUNTER_UNIT_RST_8;
    else if (bus.wr && bus.addr == `CALENDAR_COUNTER_UNIT_OFS_TRIM)
      trim_q <= bus.wdata[7:0];
  end

  // Counter advances on counter-clock ticks while the synchronised enable is set, unless a debug halt stops it
  assign run = tick && en_eff_q && (!halted || debug_q[`CALENDAR_COUNTER_UNIT_DBG_RUN]); // RULE12

  // Trim: in the first VALUE ticks of every 2^PRESC_W run ticks a step is
  // dropped (slower) or doubled (faster); zero magnitude leaves it alone.
  // Doubling skips bit 0 only, so tap edges are still all seen.
  always_comb
  begin
    presc_d = presc_q + PRESC_W'(1);
    if (trim_eff_q[6:0] != 7'h00 && trim_cnt_q < PRESC_W'(trim_eff_q[6:0])) // RULE20
    begin
      if (trim_eff_q[`CALENDAR_COUNTER_UNIT_TRIM_SIGN])
        presc_d = presc_q + PRESC_W'(2); // RULE19
      else
        presc_d = presc_q; // RULE19
    end
  end

  assign presc_wrap = presc_d < presc_q;

  // Prescaler, its period tick counter and the 32-bit count
  always_ff @(posedge core_clk)
  begin
    if (rst || soft_rst)
    begin
      presc_q    <= '0;
      trim_cnt_q <= '0;
      count_q    <= `CALENDAR_COUNTER_UNIT_RST_32;
    end
    else if (bus.wr && bus.addr == `CALENDAR_COUNTER_UNIT_OFS_COUNT)
      count_q <= bus.wdata; // RULE21
    else if (run)
    begin
      presc_q    <= presc_d;
      trim_cnt_q <= trim_cnt_q + PRESC_W'(1);
      if (presc_wrap)
        count_q <= count_q + 32'h1; // RULE21
    end
  end

  // Wrap is registered so the flag rises one counter cycle later
  always_ff @(posedge core_clk)
  begin
    if (rst || soft_rst)
      wrap_q <= 1'b0;
    else
      wrap_q <= run && presc_wrap && count_q == 32'hFFFFFFFF; // RULE4
  end

  // Periodic events on rising prescaler taps
  always_comb
  begin
    for (int n = 0; n < 8; n++)
      per_edge[n] = run && !presc_q[n + `CALENDAR_COUNTER_UNIT_PER_TAP] && presc_d[n + `CALENDAR_COUNTER_UNIT_PER_TAP]; // RULE9
  end

  // Hardware events that set flags
  always_comb
  begin
    flag_set                  = {8'h00, per_edge};
    flag_set[`CALENDAR_COUNTER_UNIT_BIT_WRAP]   = wrap_q; // RULE4
    flag_set[`CALENDAR_COUNTER_UNIT_BIT_TAMPER] = tamper_ev; // RULE7
  end

  // Write-one-to-clear, with a same-cycle set taking priority
  assign flags_d = (flags_q & ~(allow ? wr_ones(bus, `CALENDAR_COUNTER_UNIT_OFS_FLAGS) : `CALENDAR_COUNTER_UNIT_RST_16)) | flag_set; // RULE22

  always_ff @(posedge core_clk)
  begin
    if (rst || soft_rst)
      flags_q <= `CALENDAR_COUNTER_UNIT_RST_16;
    else
      flags_q <= flags_d; // RULE6 RULE8 RULE11
  end

  // One shared enable set, reached through both set and clear offsets
  always_ff @(posedge core_clk)
  begin
    if (rst || soft_rst)
      enable_q <= `CALENDAR_COUNTER_UNIT_RST_16;
    else
      enable_q <= (enable_q | wr_ones(bus, `CALENDAR_COUNTER_UNIT_OFS_EN_SET)) & ~wr_ones(bus, `CALENDAR_COUNTER_UNIT_OFS_EN_CLEAR); // RULE1 RULE2 RULE3
  end

  // Interrupt request from flopped flags and enables
  always_ff @(posedge core_clk)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(flags_q & enable_q); // RULE5 RULE7 RULE10 RULE23
  end

  // Count snapshot: a copy of the count one cycle late, read back when read sync is on
  always_ff @(posedge core_clk)
  begin
    if (rst || soft_rst)
      count_snap_q <= `CALENDAR_COUNTER_UNIT_RST_32;
    else
      count_snap_q <= count_q;
  end

  always_comb
  begin
    busy_word                     = `CALENDAR_COUNTER_UNIT_RST_32;
    busy_word[`CALENDAR_COUNTER_UNIT_BUSY_SOFT_RST] = busy[CALENDAR_COUNTER_UNIT_SY_SOFT_RST]; // RULE18
    busy_word[`CALENDAR_COUNTER_UNIT_BUSY_ENABLE] = busy[CALENDAR_COUNTER_UNIT_SY_ENABLE]; // RULE17
    busy_word[`CALENDAR_COUNTER_UNIT_BUSY_TRIM]   = busy[CALENDAR_COUNTER_UNIT_SY_TRIM]; // RULE16
    busy_word[`CALENDAR_COUNTER_UNIT_BUSY_COUNT]  = busy[CALENDAR_COUNTER_UNIT_SY_COUNT]; // RULE15
    busy_word[`CALENDAR_COUNTER_UNIT_BUSY_RSYNC]  = busy[CALENDAR_COUNTER_UNIT_SY_RSYNC]; // RULE14
  end

  // Read data one cycle after the strobe; barred offsets read zero in soft reset
  always_ff @(posedge core_clk)
  begin
    if (rst)
      rd_data <= `CALENDAR_COUNTER_UNIT_RST_32;
    else if (!bus.rd)
      rd_data <= `CALENDAR_COUNTER_UNIT_RST_32;
    else
    begin
      case (bus.addr)
        `CALENDAR_COUNTER_UNIT_OFS_MAIN_CTRL: rd_data <= {16'h0000, ctrl_rsync_q, 13'h0000, ctrl_en_q, soft_rst};
        `CALENDAR_COUNTER_UNIT_OFS_BUSY:      rd_data <= busy_word;
        `CALENDAR_COUNTER_UNIT_OFS_EN_CLEAR,
        `CALENDAR_COUNTER_UNIT_OFS_EN_SET:    rd_data <= allow ? {16'h0000, enable_q} : `CALENDAR_COUNTER_UNIT_RST_32; // RULE3
        `CALENDAR_COUNTER_UNIT_OFS_FLAGS:     rd_data <= allow ? {16'h0000, flags_q} : `CALENDAR_COUNTER_UNIT_RST_32;
        `CALENDAR_COUNTER_UNIT_OFS_DEBUG:     rd_data <= allow ? {24'h000000, debug_q} : `CALENDAR_COUNTER_UNIT_RST_32;
        `CALENDAR_COUNTER_UNIT_OFS_TRIM:      rd_data <= allow ? {24'h000000, trim_q} : `CALENDAR_COUNTER_UNIT_RST_32;
        `CALENDAR_COUNTER_UNIT_OFS_COUNT:     rd_data <= ctrl_rsync_q ? count_snap_q : count_q; // RULE21
        default:             rd_data <= `CALENDAR_COUNTER_UNIT_RST_32;
      endcase
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  enset_wrap_a: assert property ( // RULE1
    bus.wr && bus.addr == `CALENDAR_COUNTER_UNIT_OFS_EN_SET && bus.wdata[15] && !soft_rst
    && !(bus.addr == `CALENDAR_COUNTER_UNIT_OFS_EN_CLEAR) |=> enable_q[`CALENDAR_COUNTER_UNIT_BIT_WRAP])
    else $error("wrap enable not set by enable-set write");

  enset_zero_a: assert property ( // RULE2
    bus.wr && bus.addr == `CALENDAR_COUNTER_UNIT_OFS_EN_SET && !soft_rst |=> (enable_q & $past(enable_q)) == $past(enable_q))
    else $error("enable-set write dropped an enable");

  enclr_shared_a: assert property ( // RULE3
    bus.wr && bus.addr == `CALENDAR_COUNTER_UNIT_OFS_EN_CLEAR && bus.wdata[0] && !soft_rst |=> !enable_q[0])
    else $error("enable-clear did not act on shared enables");

  wrap_flag_a: assert property ( // RULE4
    run && presc_wrap && count_q == 32'hFFFFFFFF && !soft_rst |=> ##1 flags_q[`CALENDAR_COUNTER_UNIT_BIT_WRAP])
    else $error("wrap flag not set after wrap");

  irq_cause_a: assert property ( // RULE23
    ##1 irq == |($past(flags_q) & $past(enable_q)))
    else $error("interrupt request does not match flags and enables");

  wrap_irq_a: assert property ( // RULE5
    flags_q[`CALENDAR_COUNTER_UNIT_BIT_WRAP] && enable_q[`CALENDAR_COUNTER_UNIT_BIT_WRAP] |=> irq)
    else $error("wrap flag with enable gave no request");

  flag_clear_a: assert property ( // RULE6
    bus.wr && bus.addr == `CALENDAR_COUNTER_UNIT_OFS_FLAGS && bus.wdata[15] && !soft_rst && !wrap_q
    |=> !flags_q[`CALENDAR_COUNTER_UNIT_BIT_WRAP])
    else $error("wrap flag not cleared by write of one");

  set_wins_a: assert property ( // RULE22
    tamper_ev && !soft_rst |=> flags_q[`CALENDAR_COUNTER_UNIT_BIT_TAMPER])
    else $error("tamper event lost");

  per_flag_a: assert property ( // RULE9
    per_edge[0] && !soft_rst |=> flags_q[0])
    else $error("periodic flag 0 not set on tap edge");

  halt_stop_a: assert property ( // RULE12
    halted && !debug_q[`CALENDAR_COUNTER_UNIT_DBG_RUN] && !(bus.wr && bus.addr == `CALENDAR_COUNTER_UNIT_OFS_COUNT) && !soft_rst
    |=> $stable(presc_q))
    else $error("counter moved during debug halt");

  dbg_keep_a: assert property ( // RULE13
    soft_rst && !(bus.wr && bus.addr == `CALENDAR_COUNTER_UNIT_OFS_DEBUG) |=> $stable(debug_q))
    else $error("debug control lost in soft reset");

  trim_busy_a: assert property ( // RULE16
    sync_start[CALENDAR_COUNTER_UNIT_SY_TRIM] |=> busy_word[`CALENDAR_COUNTER_UNIT_BUSY_TRIM] [*4])
    else $error("trim busy too short");

  trim_idle_a: assert property ( // RULE16
    sync_start[CALENDAR_COUNTER_UNIT_SY_TRIM] ##1 (!sync_start[CALENDAR_COUNTER_UNIT_SY_TRIM]) [*4] |=> !busy_word[`CALENDAR_COUNTER_UNIT_BUSY_TRIM])
    else $error("trim busy did not end");

  soft_busy_a: assert property ( // RULE18
    sync_start[CALENDAR_COUNTER_UNIT_SY_SOFT_RST] |=> soft_rst [*4] ##1 !soft_rst)
    else $error("soft reset busy length wrong");

  count_busy_a: assert property ( // RULE15
    sync_start[CALENDAR_COUNTER_UNIT_SY_COUNT] |=> busy_word[`CALENDAR_COUNTER_UNIT_BUSY_COUNT])
    else $error("count busy not raised");

  trim_off_a: assert property ( // RULE20
    run && trim_eff_q[6:0] == 7'h00 |-> presc_d == presc_q + PRESC_W'(1))
    else $error("zero trim altered the rate");

endmodule : calendar_counter_unit_regs

// ===== sim/calendar_counter_unit_regs_tb.sv
// Self-checking bench for the real-time counter control and flag registers
`timescale 1ns/1ps
`include "calendar_counter_unit_map.svh"

module calendar_counter_unit_regs_tb
  import calendar_counter_unit_pkg::*;
;
  logic        core_clk;
  logic        rst;
  calendar_counter_unit_bus_t   bus;
  logic        counter_clock;
  logic        tamper_in;
  logic        debug_halt;
  logic [31:0] rd_data;
  logic        irq;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [7:0]  adr_q[$];
  logic        pend;
  int          errors;
  int          num_checks;
  int          cyc;
  logic [15:0] r1;
  logic [15:0] r2;
  logic [7:0]  rst_ofs[6];

  calendar_counter_unit_regs calendar_counter_unit_regs_i (
    .core_clk      (core_clk),
    .rst           (rst),
    .bus           (bus),
    .counter_clock (counter_clock),
    .tamper_in     (tamper_in),
    .debug_halt    (debug_halt),
    .rd_data       (rd_data),
    .irq           (irq)
  );

  // Clock at 200 MHz
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic test_done;
    if (errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask : idle

  // One-cycle write strobe; an idle cycle follows before the next access
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus.wr    <= 1'b1;
    bus.addr  <= a;
    bus.wdata <= d;
    @(posedge core_clk);
    bus.wr    <= 1'b0;
  endtask : wr

  // Read strobe; the expected word is noted for the watcher
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
    @(posedge core_clk);
    bus.rd   <= 1'b1;
    bus.addr <= a;
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    adr_q.push_back(a);
    @(posedge core_clk);
    bus.rd   <= 1'b0;
  endtask : rd

  // Counter clock pulses, slow enough for the two-stage synchroniser
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      counter_clock <= 1'b1;
      idle(2);
      counter_clock <= 1'b0;
      idle(1);
    end
    idle(8);
  endtask : ticks

  task automatic chk_irq(input logic e);
    idle(4);
    check("irq", {31'h0, e}, {31'h0, irq});
  endtask : chk_irq

  // Read data stand in the cycle after the strobe, so look one negedge later
  initial pend = 1'b0;
  always @(negedge core_clk)
  begin
    if (pend)
    begin
      if (exp_q.size() == 0)
        check("queue", 32'h0, 32'h1);
      else
        check($sformatf("reg %h", adr_q.pop_front()), exp_q.pop_front(), rd_data & msk_q.pop_front());
    end
    else if (rd_data !== 32'h0)
      check("idle rd_data", 32'h0, rd_data);
    pend = bus.rd;
  end

  // Hang guard, well above the roughly 4600 cycles the sequence needs
  initial cyc = 0;
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      test_done();
    end
  end

  initial
  begin
    errors = 0;
    num_checks = 0;
    bus = '0;
    counter_clock = 1'b0;
    tamper_in = 1'b0;
    debug_halt = 1'b0;
    rst = 1'b1;
    rst_ofs = '{8'h0A, 8'h0C, 8'h0E, 8'h10, 8'h14, 8'h18};
    void'($urandom(87));
    idle(3);
    rst <= 1'b0;
    // Reset values and an unmapped place
    foreach (rst_ofs[i]) rd(rst_ofs[i], 32'h0);
    wr(8'h30, 32'hFFFFFFFF);
    rd(8'h30, 32'h0);
    // Set and clear share one enable set
    r1 = 16'($urandom) & 16'hC0FF;
    r2 = 16'($urandom) & r1;
    wr(`CALENDAR_COUNTER_UNIT_OFS_EN_SET, {16'h0, r1});
    rd(`CALENDAR_COUNTER_UNIT_OFS_EN_SET, {16'h0, r1});
    wr(`CALENDAR_COUNTER_UNIT_OFS_EN_SET, 32'h0);
    rd(`CALENDAR_COUNTER_UNIT_OFS_EN_CLEAR, {16'h0, r1});
    wr(`CALENDAR_COUNTER_UNIT_OFS_EN_CLEAR, {16'h0, r2});
    rd(`CALENDAR_COUNTER_UNIT_OFS_EN_SET, {16'h0, r1 & ~r2});
    wr(`CALENDAR_COUNTER_UNIT_OFS_EN_CLEAR, 32'h0000FFFF);
    // Trim write shows busy while crossing, then reads back
    wr(`CALENDAR_COUNTER_UNIT_OFS_TRIM, 32'h00000085);
    rd(`CALENDAR_COUNTER_UNIT_OFS_BUSY, 32'h00000004);
    idle(10);
    rd(`CALENDAR_COUNTER_UNIT_OFS_TRIM, 32'h00000085);
    wr(`CALENDAR_COUNTER_UNIT_OFS_TRIM, 32'h0);
    idle(10);
    wr(`CALENDAR_COUNTER_UNIT_OFS_MAIN_CTRL, 32'h00000002);
    rd(`CALENDAR_COUNTER_UNIT_OFS_BUSY, 32'h00008002);
    idle(10);
    rd(`CALENDAR_COUNTER_UNIT_OFS_BUSY, 32'h0);
    // Sixteen ticks raise prescaler bits 2, 3 and 4
    ticks(16);
    rd(`CALENDAR_COUNTER_UNIT_OFS_FLAGS, 32'h00000007);
    wr(`CALENDAR_COUNTER_UNIT_OFS_EN_SET, 32'h000000FF);
    chk_irq(1'b1);
    wr(`CALENDAR_COUNTER_UNIT_OFS_FLAGS, 32'h0);
    rd(`CALENDAR_COUNTER_UNIT_OFS_FLAGS, 32'h00000007);
    wr(`CALENDAR_COUNTER_UNIT_OFS_FLAGS, 32'h00000005);
    rd(`CALENDAR_COUNTER_UNIT_OFS_FLAGS, 32'h00000002);
    chk_irq(1'b1);
    wr(`CALENDAR_COUNTER_UNIT_OFS_FLAGS, 32'h00000002);
    chk_irq(1'b0);
    // Debug halt freezes the prescaler unless run-while-halted is set
    debug_halt <= 1'b1;
    idle(8);
    ticks(16);
    rd(`CALENDAR_COUNTER_UNIT_OFS_FLAGS, 32'h0);
    wr(`CALENDAR_COUNTER_UNIT_OFS_DEBUG, 32'h00000001);
    idle(4);
    ticks(16);
    rd(`CALENDAR_COUNTER_UNIT_OFS_FLAGS, 32'h0000000B);
    debug_halt <= 1'b0;
    // Count wraps once from all ones
    wr(`CALENDAR_COUNTER_UNIT_OFS_FLAGS, 32'h0000FFFF);
    wr(`CALENDAR_COUNTER_UNIT_OFS_COUNT, 32'hFFFFFFFF);
    rd(`CALENDAR_COUNTER_UNIT_OFS_BUSY, 32'h00000008);
    idle(10);
    wr(`CALENDAR_COUNTER_UNIT_OFS_EN_CLEAR, 32'h000000FF);
    wr(`CALENDAR_COUNTER_UNIT_OFS_EN_SET, 32'h00008000);
    chk_irq(1'b0);
    ticks(1030);
    rd(`CALENDAR_COUNTER_UNIT_OFS_FLAGS, 32'h000080FF);
    chk_irq(1'b1);
    wr(`CALENDAR_COUNTER_UNIT_OFS_FLAGS, 32'h00008000);
    rd(`CALENDAR_COUNTER_UNIT_OFS_FLAGS, 32'h000000FF);
    chk_irq(1'b0);
    rd(`CALENDAR_COUNTER_UNIT_OFS_COUNT, 32'h0);
    // Tamper event
    wr(`CALENDAR_COUNTER_UNIT_OFS_FLAGS, 32'h0000FFFF);
    tamper_in <= 1'b1;
    idle(8);
    tamper_in <= 1'b0;
    rd(`CALENDAR_COUNTER_UNIT_OFS_FLAGS, 32'h00004000);
    wr(`CALENDAR_COUNTER_UNIT_OFS_EN_SET, 32'h00004000);
    chk_irq(1'b1);
    wr(`CALENDAR_COUNTER_UNIT_OFS_FLAGS, 32'h0);
    rd(`CALENDAR_COUNTER_UNIT_OFS_FLAGS, 32'h00004000);
    wr(`CALENDAR_COUNTER_UNIT_OFS_FLAGS, 32'h00004000);
    rd(`CALENDAR_COUNTER_UNIT_OFS_FLAGS, 32'h0);
    chk_irq(1'b0);
    // Soft reset keeps run-while-halted; only busy is touched until it ends
    wr(`CALENDAR_COUNTER_UNIT_OFS_MAIN_CTRL, 32'h00000001);
    rd(`CALENDAR_COUNTER_UNIT_OFS_BUSY, 32'h00000001, 32'h00000001);
    idle(12);
    rd(`CALENDAR_COUNTER_UNIT_OFS_BUSY, 32'h0);
    rd(`CALENDAR_COUNTER_UNIT_OFS_DEBUG, 32'h00000001);
    rd(`CALENDAR_COUNTER_UNIT_OFS_EN_SET, 32'h0);
    // Faster trim doubles the first two steps after soft reset, so tap 2 rises early
    wr(`CALENDAR_COUNTER_UNIT_OFS_TRIM, 32'h00000082);
    idle(10);
    wr(`CALENDAR_COUNTER_UNIT_OFS_MAIN_CTRL, 32'h00008002);
    idle(10);
    ticks(2);
    rd(`CALENDAR_COUNTER_UNIT_OFS_FLAGS, 32'h00000001);
    rd(`CALENDAR_COUNTER_UNIT_OFS_COUNT, 32'h0);
    idle(4);
    test_done();
  end
endmodule : calendar_counter_unit_regs_tb
